/* File: shared/sfbr_defs.vh */
// Constants for the flag-byte SPI register port.
// Assumes inclusion by bare name from the design files.
`ifndef SFBR_DEFS_VH
`define SFBR_DEFS_VH
`define SFBR_FLAG_WRITE   8'h57
`define SFBR_FLAG_STICKY  8'h53
`define SFBR_FLAG_READ    8'h52
`define SFBR_ADDR_W       8
`define SFBR_MEM_DEPTH    256
`define SFBR_PTR_RESET    8'h00
`define SFBR_MAX_SCK_KHZ  1000
`define SFBR_SETUP_US     50
`define SFBR_CLK_MHZ      100
`endif

/* File: hdl/sfbr_sync.v */
// Two-flop synchroniser for one asynchronous level.
// Assumes the input is quasi-static relative to i_ref_clk.
`default_nettype none
module sfbr_sync
(
  // Clock and reset
  input  wire i_ref_clk,
  input  wire i_reset,
  input  wire i_reset_val,
  // Level in and out
  input  wire i_async,
  output wire o_sync
);
  reg meta_q;
  reg sync_q;
  always @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      meta_q <= i_reset_val;
      sync_q <= i_reset_val;
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end
  // Reset to the pin's idle level so no false edge follows reset
  assign o_sync = sync_q;
endmodule
`default_nettype wire

/* File: hdl/sfbr_port.v */
// Flag-byte SPI slave port onto a byte-addressed register memory.
// Assumes the SPI master keeps its own timing; pins sampled by i_ref_clk.
`default_nettype none
`include "sfbr_defs.vh"
module sfbr_port
(
  // Clock and reset
  input  wire       i_ref_clk,
  input  wire       i_reset,
  // SPI pins
  input  wire       i_spi_sck,
  input  wire       i_spi_cs_n,
  input  wire       i_spi_mosi,
  output reg        o_spi_miso,
  output wire       o_spi_miso_oe_n,
  // Internal memory read-back
  input  wire [7:0] i_peek_addr,
  output reg  [7:0] o_peek_data,
  // Status
  output reg  [7:0] o_read_ptr,
  output reg        o_sticky,
  output reg        o_frame_done
);
  // ****************************************************************
  // Memory and constants
  // ****************************************************************
  localparam ST_FLAG = 2'd0;
  localparam ST_ADDR = 2'd1;
  localparam ST_DATA = 2'd2;
  localparam ST_READ = 2'd3;
  // Memory holds the whole 8-bit address space
  reg [7:0] mem_q [0:`SFBR_MEM_DEPTH-1];

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  wire sck_s;
  wire cs_n_s;
  wire mosi_s;
  sfbr_sync u_sync_sck
  (
    .i_ref_clk   (i_ref_clk),
    .i_reset     (i_reset),
    .i_reset_val (1'b1),
    .i_async     (i_spi_sck),
    .o_sync      (sck_s)
  );
  sfbr_sync u_sync_cs
  (
    .i_ref_clk   (i_ref_clk),
    .i_reset     (i_reset),
    .i_reset_val (1'b1),
    .i_async     (i_spi_cs_n),
    .o_sync      (cs_n_s)
  );
  sfbr_sync u_sync_mosi
  (
    .i_ref_clk   (i_ref_clk),
    .i_reset     (i_reset),
    .i_reset_val (1'b1),
    .i_async     (i_spi_mosi),
    .o_sync      (mosi_s)
  );

  reg        sck_q;
  reg        cs_n_q;
  reg  [1:0] state_q;
  reg  [2:0] bit_q;
  reg  [6:0] sh_q;
  reg  [7:0] tx_q;
  reg  [7:0] addr_q;
  reg  [7:0] wcnt_q;
  reg  [7:0] rcnt_q;
  reg  [7:0] first_q;
  reg  [7:0] ptr_q;
  reg        sticky_q;
  reg        wsticky_q;
  reg        ignore_q;

  wire       rise = sck_s & ~sck_q;
  wire       fall = ~sck_s & sck_q;
  wire       active = ~cs_n_s;
  wire [7:0] rx_byte = {sh_q, mosi_s};
  wire       byte_end = rise & active & (bit_q == 3'd7);
  wire       cs_rise = cs_n_s & ~cs_n_q;

  // MISO only driven during a frame; enable active low
  assign o_spi_miso_oe_n = cs_n_s;

  // ****************************************************************
  // Frame engine
  // ****************************************************************
  always @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      sck_q        <= 1'b1;
      cs_n_q       <= 1'b1;
      state_q      <= ST_FLAG;
      bit_q        <= 3'd0;
      sh_q         <= 7'h00;
      tx_q         <= 8'h00;
      addr_q       <= 8'h00;
      wcnt_q       <= 8'h00;
      rcnt_q       <= 8'h00;
      first_q      <= 8'h00;
      ptr_q        <= `SFBR_PTR_RESET;
      sticky_q     <= 1'b0;
      wsticky_q    <= 1'b0;
      ignore_q     <= 1'b0;
      o_spi_miso   <= 1'b1;
      o_read_ptr   <= `SFBR_PTR_RESET;
      o_sticky     <= 1'b0;
      o_frame_done <= 1'b0;
      o_peek_data  <= 8'h00;
    end
    else
    begin
      sck_q        <= sck_s;
      cs_n_q       <= cs_n_s;
      o_frame_done <= 1'b0;
      o_read_ptr   <= ptr_q;
      o_sticky     <= sticky_q;
      o_peek_data  <= mem_q[i_peek_addr];
      if (cs_n_s)
      begin
        state_q <= ST_FLAG;
        bit_q   <= 3'd0;
        ignore_q <= 1'b0;
        // Pointer preloaded for the flag byte
        tx_q       <= ptr_q;
        o_spi_miso <= ptr_q[7];
      end
      if (cs_rise)
      begin
        o_frame_done <= 1'b1;
        // Lone byte after flag is the pointer
        if (state_q == ST_DATA && wcnt_q == 8'h00)
        begin
          ptr_q    <= first_q;
          sticky_q <= wsticky_q;
          o_read_ptr <= first_q;
        end
        else if (state_q == ST_READ && !sticky_q)
        begin
          ptr_q <= ptr_q + rcnt_q;
        end
      end
      else if (active)
      begin
        if (rise)
        begin
          sh_q  <= rx_byte[6:0];
          bit_q <= bit_q + 3'd1;
        end
        // MSB leaves on the leading fall of each byte
        if (fall)
        begin
          o_spi_miso <= tx_q[7];
          tx_q       <= {tx_q[6:0], 1'b0};
        end
        if (byte_end)
        begin
          case (state_q)
            ST_FLAG:
            begin
              if (rx_byte == `SFBR_FLAG_WRITE || rx_byte == `SFBR_FLAG_STICKY)
              begin
                state_q   <= ST_ADDR;
                wsticky_q <= (rx_byte == `SFBR_FLAG_STICKY);
              end
              else if (rx_byte == `SFBR_FLAG_READ)
              begin
                state_q <= ST_READ;
                rcnt_q  <= 8'h00;
                tx_q    <= mem_q[ptr_q];
              end
              else
              begin
                // Unknown flag: rest of frame ignored
                state_q  <= ST_DATA;
                wcnt_q   <= 8'h01;
                addr_q   <= 8'h00;
                ignore_q <= 1'b1;
              end
            end
            ST_ADDR:
            begin
              first_q <= rx_byte;
              addr_q  <= rx_byte;
              wcnt_q  <= 8'h00;
              state_q <= ST_DATA;
            end
            ST_DATA:
            begin
              // Sequential store; bad flag frames never store
              if (!ignore_q)
              begin
                mem_q[addr_q] <= rx_byte;
              end
              addr_q <= addr_q + 8'h01;
              wcnt_q <= (wcnt_q == 8'hFF) ? 8'hFF : wcnt_q + 8'h01;
            end
            ST_READ:
            begin
              rcnt_q <= rcnt_q + 8'h01;
              tx_q   <= mem_q[ptr_q + rcnt_q + 8'h01];
            end
            default:
            begin
              state_q <= ST_FLAG;
            end
          endcase
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/sfbr_port_properties.sv */
// Checker of SPI port timing at the pins.
// Sees only top ports; bound at the foot.
`default_nettype none
module sfbr_port_properties
(
  // Pins
  input wire logic       i_ref_clk,
  input wire logic       i_reset,
  input wire logic       i_spi_sck,
  input wire logic       i_spi_cs_n,
  input wire logic       o_spi_miso,
  input wire logic       o_spi_miso_oe_n,
  // Status
  input wire logic [7:0] o_read_ptr,
  input wire logic       o_sticky,
  input wire logic       o_frame_done
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);
  a_miso_rise_hold: assert property ($rose(i_spi_sck) && !i_spi_cs_n |=> $stable(o_spi_miso) [*4])
    else $error("miso moved");
  a_drive_in_frame: assert property (!i_spi_cs_n [*4] |-> !o_spi_miso_oe_n)
    else $error("miso not driven");
  a_release_idle: assert property (i_spi_cs_n [*4] |-> o_spi_miso_oe_n)
    else $error("miso not released");
  a_done_on_end: assert property ($rose(i_spi_cs_n) |-> ##[1:5] o_frame_done)
    else $error("no frame end");
  a_done_pulse: assert property (o_frame_done |=> !o_frame_done)
    else $error("done too long");
  a_done_late: assert property (o_frame_done |-> $past(i_spi_cs_n, 2))
    else $error("done too early");
  a_ptr_end_only: assert property ($changed(o_read_ptr) |-> i_spi_cs_n)
    else $error("ptr moved in frame");
  a_sticky_end_only: assert property ($changed(o_sticky) |-> i_spi_cs_n)
    else $error("sticky moved in frame");
  c_done: cover property (o_frame_done);
  c_sticky: cover property ($rose(o_sticky));
  c_ptr: cover property ($changed(o_read_ptr));
endmodule
bind sfbr_port sfbr_port_properties u_props (.*);
`default_nettype wire

/* File: testbench/sfbr_spi_master.sv */
// SPI master model, mode 3, MSB first.
// Called by the bench through its run task.
`default_nettype none
module sfbr_spi_master
#(
  parameter real GAP_NS = 50000.0
)
(
  // SPI pins
  output var logic o_sck,
  output var logic o_cs_n,
  output var logic o_mosi,
  input wire logic i_miso
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] tx[$];
  logic [7:0] rx[$];
  initial
  begin
    o_sck = 1'b1;
    o_cs_n = 1'b1;
    o_mosi = 1'b1;
  end
  // Bench link runs fast to keep the run short
  task automatic run();
    logic [7:0] b;
    rx.delete();
    o_cs_n = 1'b0;
    #(GAP_NS);
    foreach (tx[i])
    begin
      for (int k = 7; k >= 0; k--)
      begin
        o_sck = 1'b0;
        o_mosi = tx[i][k];
        #62.5;
        o_sck = 1'b1;
        b[k] = i_miso;
        #62.5;
      end
      rx.push_back(b);
    end
    #(GAP_NS);
    // Idle data line must not look held
    o_mosi = ~o_mosi;
    o_cs_n = 1'b1;
    #(GAP_NS);
  endtask
endmodule
`default_nettype wire

/* File: testbench/sfbr_port_tb.sv */
// Bench for the flag-byte SPI register port.
// Master model drives pins; memory seen via peek port.
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; $display("BAD %0t %h/%h", $time, a, e); end end
module sfbr_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       sck, cs_n, mosi, miso, oe_n, sticky, done;
  logic [7:0] paddr = 8'h00;
  logic [7:0] pdata, ptr, a;
  logic [7:0] d[3];
  integer     seed = 59627;
  int         n_errors = 0;
  int         n_compared = 0;
  int         cyc = 0;
  sfbr_port u_dut (.i_ref_clk(clk), .i_reset(rst), .i_spi_sck(sck), .i_spi_cs_n(cs_n), .i_spi_mosi(mosi),
    .o_spi_miso(miso), .o_spi_miso_oe_n(oe_n), .i_peek_addr(paddr), .o_peek_data(pdata),
    .o_read_ptr(ptr), .o_sticky(sticky), .o_frame_done(done));
  // Gap cut to 5 us to keep the run short
  sfbr_spi_master #(.GAP_NS(5000.0)) u_mst (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso));
  initial
  begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_errors++;
      finish_test();
    end
  end
  function automatic logic [7:0] nxt(input logic [7:0] p, input logic s, input logic [7:0] n);
    return s ? p : p + n;
  endfunction
  task automatic send(input logic [7:0] b[$]);
    // Offset keeps link edges off both clock edges
    @(negedge clk);
    #2;
    u_mst.tx = b;
    u_mst.run();
  endtask
  task automatic peek(input logic [7:0] ad, input logic [7:0] e);
    @(negedge clk) paddr = ad;
    repeat (2) @(negedge clk);
    `CHK(pdata, e)
  endtask
  task automatic finish_test();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    a = 8'($random(seed)) & 8'h7f;
    foreach (d[i]) d[i] = 8'($random(seed));
    // Replies to write frames go unchecked
    send('{8'h57, a, d[0], d[1], d[2]});
    foreach (d[i]) peek(a + 8'(i), d[i]);
    `CHK(ptr, 8'h00)
    $display("done: write");
    send('{8'h57, a});
    `CHK(ptr, a)
    send('{8'h52, 8'($random(seed)), 8'($random(seed)), 8'($random(seed))});
    `CHK(u_mst.rx[0], a)
    foreach (d[i]) `CHK(u_mst.rx[i + 1], d[i])
    `CHK(ptr, nxt(a, 1'b0, 8'h03))
    $display("done: read");
    send('{8'h53, a});
    `CHK(sticky, 1'b1)
    repeat (2)
    begin
      send('{8'h52, 8'hff, 8'hff});
      `CHK(u_mst.rx[2], d[1])
      `CHK(ptr, nxt(a, 1'b1, 8'h02))
    end
    send('{8'h57, a + 8'h01});
    `CHK(sticky, 1'b0)
    send('{8'h41, a, ~d[0]});
    peek(a, d[0]);
    `CHK(ptr, a + 8'h01)
    $display("done: sticky and flags");
    finish_test();
  end
endmodule
`default_nettype wire
